// ---- adc_ctrl_pkg.sv ----
// Constants and register map shared by the converter control logic
package adc_ctrl_pkg;
    localparam int unsigned CLOCK_PERIOD_NS = 20;
    localparam int unsigned POWERUP_NS      = 5000;
    localparam logic [8:0]  POWERUP_CYCLES  = 9'((POWERUP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
    localparam logic [8:0]  CONV_CYCLES     = 9'h013;
    localparam int unsigned ADDR_W          = 2;
    localparam int unsigned CODE_W          = 14;
    localparam int unsigned WORD_W          = 16;
    localparam logic [1:0]  ADDR_CONTROL    = 2'h0;
    localparam logic [1:0]  ADDR_STATUS     = 2'h1;
    localparam logic [1:0]  ADDR_RESULT     = 2'h2;
    localparam int unsigned PM_LSB          = 0;
    localparam logic [1:0]  PM_RESET        = 2'h0;
    localparam logic [1:0]  PM_SLEEP_PIN    = 2'h0;
    localparam logic [1:0]  PM_FULL_BETWEEN = 2'h1;
    localparam logic [1:0]  PM_FULL_DOWN    = 2'h2;
    localparam logic [1:0]  PM_PART_BETWEEN = 2'h3;
    localparam logic [13:0] CODE_MAX        = 14'h3fff;
endpackage : adc_ctrl_pkg

// ---- adc_range_coding_power_mgmt.sv ----
// Range coding and power management control of the 14-bit converter
// Notes on behaviour
// - Range pin low selects unipolar, high selects bipolar; host holds it.
// - Bipolar results are presented as twos complement.
// - Unipolar results are straight binary, 14 bits, step is full scale over 16384.
// - Code transitions sit half a step above each whole step.
// - Bits 00 with sleep pin high: stay fully powered, never power down.
// - Bits 00 with sleep pin low: full power-down between conversions.
// - Sleep pin ignored otherwise: 01 full between, 10 full down, 11 partial between.
// - Full power-down turns everything off; partial keeps the reference on.
// - Both power bits reset to zero.
// - Between-conversion power-down is entered when busy falls.
// - Power-up starts on start pulse falling edge; host holds it low 5 us.
// - Result word is two zero bits then the 14-bit code.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module adc_range_coding_power_mgmt (
    input  wire logic                          clock_i,              // Master clock, 50 MHz
    input  wire logic                          rst_i,                // Synchronous reset, active high
    input  wire logic                          range_select_pin_i,   // 0 unipolar, 1 bipolar
    input  wire logic                          sleep_n_i,            // Sleep pin, active low
    input  wire logic                          conversion_start_n_i, // Start pulse, rising edge converts
    input  wire logic [adc_ctrl_pkg::CODE_W:0] sample_i,             // Comparator value in half steps
    input  wire logic [adc_ctrl_pkg::ADDR_W-1:0] addr_i,             // Register address
    input  wire logic [31:0]                   wdata_i,              // Register write data
    input  wire logic                          wr_i,                 // Write strobe
    input  wire logic                          rd_i,                 // Read strobe
    output logic      [31:0]                   rdata_o,              // Read data, cycle after strobe
    output logic                               busy_o,               // Conversion in progress
    output logic                               core_power_on_o,      // Converter circuitry powered
    output logic                               ref_power_on_o,       // Reference powered
    output logic      [adc_ctrl_pkg::WORD_W-1:0] result_o,           // Formatted result word
    output logic                               result_valid_o        // Unread result present
);
    import adc_ctrl_pkg::*;

    typedef enum logic [1:0] {ST_UP, ST_CONV, ST_DOWN, ST_WAKE} mode_t;

    typedef struct packed {
        logic [1:0]        pm;
        mode_t             mode;
        logic [8:0]        cnt;
        logic              range;
        logic              busy;
        logic [WORD_W-1:0] result;
        logic              valid;
        logic [31:0]       rdata;
        logic              cs_prev;
        logic              core_on;
        logic              ref_on;
        logic [CODE_W-1:0] code_q;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    logic              cs_fall;
    logic              cs_rise;
    logic              down_after;
    logic [CODE_W:0]   rounded;
    logic [CODE_W-1:0] code14;

    always_comb begin
        cs_fall    = s_r.cs_prev & ~conversion_start_n_i;
        cs_rise    = ~s_r.cs_prev & conversion_start_n_i;
        down_after = (s_r.pm == PM_FULL_BETWEEN) || (s_r.pm == PM_PART_BETWEEN)
                     || ((s_r.pm == PM_SLEEP_PIN) && !sleep_n_i);
        // Half-step input rounds to the nearest whole step, saturating at the top code
        rounded    = (CODE_W + 1)'({1'b0, sample_i[CODE_W:1]} + {{CODE_W{1'b0}}, sample_i[0]});
        code14     = rounded[CODE_W] ? CODE_MAX : rounded[CODE_W-1:0];
    end

    always_comb begin
        s_nxt         = s_r;
        s_nxt.cs_prev = conversion_start_n_i;
        s_nxt.code_q  = code14;
        s_nxt.rdata   = 32'h0000_0000;
        if (wr_i && addr_i == ADDR_CONTROL) begin
            s_nxt.pm = wdata_i[PM_LSB +: 2];
        end
        if (rd_i) begin
            unique case (addr_i)
                ADDR_CONTROL: s_nxt.rdata = {30'h0000_0000, s_r.pm};
                ADDR_STATUS:  s_nxt.rdata = {26'h000_0000, s_r.ref_on, s_r.core_on,
                                             s_r.valid, s_r.busy, s_r.range, s_r.mode == ST_WAKE};
                ADDR_RESULT:  s_nxt.rdata = {16'h0000, s_r.result};
                default:      s_nxt.rdata = 32'h0000_0000;
            endcase
        end
        if (rd_i && addr_i == ADDR_RESULT) begin
            s_nxt.valid = 1'b0;
        end
        unique case (s_r.mode)
            ST_UP: begin
                if (s_r.pm == PM_FULL_DOWN) begin
                    s_nxt.mode    = ST_DOWN;
                    s_nxt.core_on = 1'b0;
                    s_nxt.ref_on  = 1'b0;
                end else if (cs_rise) begin
                    s_nxt.mode  = ST_CONV;
                    s_nxt.cnt   = 9'h000;
                    s_nxt.busy  = 1'b1;
                    s_nxt.range = range_select_pin_i;
                end
            end
            ST_CONV: begin
                if (s_r.cnt == CONV_CYCLES - 9'h001) begin
                    s_nxt.busy   = 1'b0;
                    s_nxt.valid  = 1'b1;
                    // Bipolar coding is offset binary with the top bit turned over
                    s_nxt.result = {2'b00, code14[CODE_W-1] ^ s_r.range, code14[CODE_W-2:0]};
                    if (down_after) begin
                        s_nxt.mode    = ST_DOWN;
                        s_nxt.core_on = 1'b0;
                        s_nxt.ref_on  = (s_r.pm == PM_PART_BETWEEN);
                    end else begin
                        s_nxt.mode = ST_UP;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt + 9'h001;
                end
            end
            ST_DOWN: begin
                if ((cs_fall && s_r.pm != PM_FULL_DOWN)
                    || (s_r.pm == PM_SLEEP_PIN && sleep_n_i)) begin
                    s_nxt.mode    = ST_WAKE;
                    s_nxt.cnt     = 9'h000;
                    s_nxt.core_on = 1'b1;
                    s_nxt.ref_on  = 1'b1;
                end
            end
            ST_WAKE: begin
                // Host keeps the pulse low long enough; a start during wake still converts
                if (cs_rise) begin
                    s_nxt.mode  = ST_CONV;
                    s_nxt.cnt   = 9'h000;
                    s_nxt.busy  = 1'b1;
                    s_nxt.range = range_select_pin_i;
                end else if (s_r.cnt == POWERUP_CYCLES - 9'h001) begin
                    s_nxt.mode = ST_UP;
                end else begin
                    s_nxt.cnt = s_r.cnt + 9'h001;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_r         <= '0;
            s_r.pm      <= PM_RESET;
            s_r.mode    <= ST_UP;
            s_r.cs_prev <= 1'b1;
            s_r.core_on <= 1'b1;
            s_r.ref_on  <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata_o         = s_r.rdata;
    assign busy_o          = s_r.busy;
    assign core_power_on_o = s_r.core_on;
    assign ref_power_on_o  = s_r.ref_on;
    assign result_o        = s_r.result;
    assign result_valid_o  = s_r.valid;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // Checks on power behaviour, result word and register port
    pm_reset_a: assert property ($past(rst_i) |-> s_r.pm == 2'h0 && !s_r.busy)
        else $error("power bits not zero after reset");
    always_up_a: assert property ((s_r.mode == ST_CONV && s_r.cnt == CONV_CYCLES - 9'h001 && s_r.pm == 2'h0
        && sleep_n_i) |=> s_r.core_on && s_r.mode == ST_UP)
        else $error("powered down with sleep pin high");
    full_between_a: assert property ((s_r.mode == ST_CONV && s_r.cnt == CONV_CYCLES - 9'h001
        && (s_r.pm == 2'h1 || (s_r.pm == 2'h0 && !sleep_n_i)))
        |=> $fell(s_r.busy) && !s_r.core_on && !s_r.ref_on)
        else $error("no full power-down after conversion");
    partial_down_a: assert property ((s_r.mode == ST_CONV && s_r.cnt == CONV_CYCLES - 9'h001
        && s_r.pm == 2'h3) |=> !s_r.core_on && s_r.ref_on)
        else $error("partial power-down lost reference");
    cont_down_a: assert property ((s_r.mode == ST_UP && s_r.pm == 2'h2)
        |=> s_r.mode == ST_DOWN ##1 (s_r.mode == ST_DOWN || s_r.pm != 2'h2))
        else $error("continuous power-down not held");
    wake_edge_a: assert property ((s_r.mode == ST_DOWN && s_r.cs_prev
        && !conversion_start_n_i && s_r.pm != 2'h2) |=> s_r.core_on && s_r.ref_on)
        else $error("no power-up on start falling edge");
    result_frame_a: assert property ($fell(s_r.busy) |-> s_r.result[15:14] == 2'b00
        && s_r.result[13:0] == {s_r.code_q[13] ^ s_r.range, s_r.code_q[12:0]} && s_r.valid)
        else $error("result word format wrong");
    range_hold_a: assert property ((s_r.mode == ST_CONV && $past(s_r.mode) == ST_CONV) |-> $stable(s_r.range))
        else $error("range changed during conversion");
    half_step_a: assert property ((sample_i == 15'h0001) |-> code14 == 14'h0001)
        else $error("first transition not at half step");
    pm_keep_a: assert property ((s_r.mode == ST_DOWN && !wr_i) |=> $stable(s_r.pm))
        else $error("control lost in power-down");

    control_read_a: assert property ((rd_i && addr_i == ADDR_CONTROL)
        |=> s_r.rdata == {30'h0000_0000, $past(s_r.pm)})
        else $error("control read does not return power bits");
    valid_clear_a: assert property ((rd_i && addr_i == ADDR_RESULT
        && !(s_r.mode == ST_CONV && s_r.cnt == CONV_CYCLES - 9'h001)) |=> !s_r.valid)
        else $error("result flag not cleared by read");
    conv_length_a: assert property ($rose(s_r.busy) |-> ##18 s_r.busy ##1 !s_r.busy)
        else $error("conversion length wrong");
    wake_power_a: assert property (s_r.mode == ST_WAKE |-> s_r.core_on && s_r.ref_on)
        else $error("power off while waking");
    down_core_off_a: assert property (s_r.mode == ST_DOWN |-> !s_r.core_on)
        else $error("core powered while down");
    top_code_a: assert property ((sample_i == 15'h7fff) |-> code14 == CODE_MAX)
        else $error("top code does not saturate");
    bipolar_mid_a: assert property ((s_r.mode == ST_CONV && s_r.cnt == CONV_CYCLES - 9'h001
        && s_r.range && sample_i == 15'h4000) |=> s_r.result == 16'h0000)
        else $error("bipolar mid scale not zero");
    start_latch_a: assert property (((s_r.mode == ST_WAKE || (s_r.mode == ST_UP && s_r.pm != 2'h2))
        && cs_rise) |=> s_r.busy && s_r.range == $past(range_select_pin_i))
        else $error("range not latched at start");
endmodule : adc_range_coding_power_mgmt

// ---- host_start_model.sv ----
// Host model that drives the conversion start pulse
`timescale 1ns/1ps
module host_start_model (
    input  wire logic       clock_i,   // Master clock
    input  wire logic       fire_i,    // Request one start pulse
    input  wire logic [9:0] low_i,     // Pulse low time minus one, in cycles
    output logic            start_n_o  // Start pulse to the device
);
    logic [9:0] cnt_r = 10'h000;
    always @(posedge clock_i) begin
        if (fire_i) begin
            start_n_o <= 1'b0;
            cnt_r     <= low_i;
        end else if (cnt_r != 10'h000) begin
            cnt_r <= cnt_r - 10'h001;
        end else begin
            start_n_o <= 1'b1;
        end
    end
endmodule : host_start_model

// ---- tb_adc_range_coding_power_mgmt.sv ----
// Self-checking bench for the converter range coding and power control
`timescale 1ns/1ps
module tb_adc_range_coding_power_mgmt;
    import adc_ctrl_pkg::*;
    typedef struct {logic [1:0] pm; logic sl; logic rg; logic [14:0] s; logic [15:0] r; logic c; logic f;} row_t;
    logic clock_i = 1'b0;
    logic rst = 1'b1, range = 1'b0, sleep_n = 1'b1, wr = 1'b0, rd = 1'b0, fire = 1'b0;
    logic [14:0] sample = 15'h0000;
    logic [1:0]  addr = 2'h0;
    logic [31:0] wdata = 32'h0000_0000, rdata, got;
    logic [15:0] result;
    logic        busy, core, refp, valid, start_n;
    int          mismatches = 0, compares = 0, n;
    row_t        rows [7] = '{
        '{2'h0, 1'b1, 1'b0, 15'h0000, 16'h0000, 1'b1, 1'b1},  // Stays up, zero code
        '{2'h0, 1'b1, 1'b0, 15'h0001, 16'h0001, 1'b1, 1'b1},  // First transition at half step
        '{2'h0, 1'b0, 1'b0, 15'h0003, 16'h0002, 1'b0, 1'b0},  // Sleep low: full down between
        '{2'h1, 1'b1, 1'b0, 15'h7fff, 16'h3fff, 1'b0, 1'b0},  // Full down between, top code saturates
        '{2'h3, 1'b0, 1'b1, 15'h0000, 16'h2000, 1'b0, 1'b1},  // Partial, sleep ignored, bipolar
        '{2'h3, 1'b1, 1'b1, 15'h4000, 16'h0000, 1'b0, 1'b1},  // Bipolar mid scale
        '{2'h0, 1'b1, 1'b1, 15'h7ffe, 16'h1fff, 1'b1, 1'b1}}; // Wake by bits, bipolar top
    always #10 clock_i = ~clock_i;
    host_start_model i_host_start_model (.clock_i(clock_i), .fire_i(fire), .low_i(10'd260), .start_n_o(start_n));
    adc_range_coding_power_mgmt i_adc_range_coding_power_mgmt (.clock_i(clock_i), .rst_i(rst),
        .range_select_pin_i(range), .sleep_n_i(sleep_n), .conversion_start_n_i(start_n), .sample_i(sample),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .busy_o(busy),
        .core_power_on_o(core), .ref_power_on_o(refp), .result_o(result), .result_valid_o(valid));
    task results;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task wreg(input logic [1:0] a, input logic [31:0] d);
        @(posedge clock_i) begin addr <= a; wdata <= d; wr <= 1'b1; end
        @(posedge clock_i) wr <= 1'b0;
    endtask : wreg
    task rreg(input logic [1:0] a);
        @(posedge clock_i) begin addr <= a; rd <= 1'b1; end
        @(posedge clock_i) rd <= 1'b0;
        #1 got = rdata;
    endtask : rreg
    task conv(input logic flip, input logic [15:0] er, input logic ec, input logic ef);
        @(posedge clock_i) fire <= 1'b1;
        @(posedge clock_i) fire <= 1'b0;
        repeat (3) @(posedge clock_i);
        #1 chk({31'h0, core}, 32'h1);
        for (n = 0; n < 400 && busy !== 1'b1; n++) begin @(posedge clock_i); #1; end
        for (n = 0; n < 40 && busy === 1'b1; n++) begin
            @(posedge clock_i);
            if (flip && n == 2) range <= ~range;
            #1;
        end
        chk(n, 32'(CONV_CYCLES));
        chk({result, valid, core, refp}, {er, 1'b1, ec, ef});
    endtask : conv
    initial begin
        repeat (20) @(posedge clock_i);
        rst <= 1'b0;
        rreg(ADDR_CONTROL); chk(got, 32'h0);
        rreg(ADDR_STATUS); chk(got, 32'h30);
        rreg(2'h3); chk(got, 32'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            wreg(ADDR_CONTROL, {30'h0, rows[i].pm});
            sleep_n <= rows[i].sl;
            range <= rows[i].rg;
            sample <= rows[i].s;
            conv(1'b0, rows[i].r, rows[i].c, rows[i].f);
            rreg(ADDR_CONTROL); chk(got, {30'h0, rows[i].pm});
            rreg(ADDR_RESULT); chk(got[15:0], rows[i].r);
            #1 chk({31'h0, valid}, 32'h0);
            $display("test row %0d done", i);
        end
        wreg(ADDR_CONTROL, {30'h0, PM_FULL_DOWN});
        repeat (2) @(posedge clock_i);
        #1 chk({core, refp}, 2'b00);
        @(posedge clock_i) fire <= 1'b1;
        @(posedge clock_i) fire <= 1'b0;
        repeat (300) @(posedge clock_i);
        #1 chk({busy, core, refp}, 3'b000);
        rreg(ADDR_CONTROL); chk(got, {30'h0, PM_FULL_DOWN});
        wreg(ADDR_CONTROL, {30'h0, PM_SLEEP_PIN});
        repeat (2) @(posedge clock_i);
        #1 chk({core, refp}, 2'b11);
        rreg(ADDR_STATUS); chk(got, 32'h33);
        $display("test continuous down done");
        @(posedge clock_i) begin range <= 1'b0; sample <= 15'h0004; end
        conv(1'b1, 16'h0002, 1'b1, 1'b1);
        $display("test range latch done");
        wreg(ADDR_CONTROL, {30'h0, PM_PART_BETWEEN});
        @(posedge clock_i) rst <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst <= 1'b0;
        rreg(ADDR_CONTROL); chk(got, 32'h0);
        rreg(ADDR_STATUS); chk(got, 32'h30);
        $display("test mid-run reset done");
        results();
    end
    initial begin
        #400000;
        mismatches++;
        results();
    end
endmodule : tb_adc_range_coding_power_mgmt
